// ==== bench/scdr_regs_monitor.sv ====
`timescale 1ns/1ps
module scdr_mon (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire scdr_pkg::scdr_divider_type DIVIDER_O,
  input wire logic ACK_O
);
  // ====================
  // bus and divider checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff SYS_RST_I;
  sequence wr(logic [5:0] i);
    CYC_I && STB_I && !ACK_O && WE_I && SEL_I[0] && ADR_I[7:2] == i;
  endsequence
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack");
  chk_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack");
  chk_c_top: assert property (wr(6'h14) |=> DIVIDER_O[32:28] == $past(DAT_I[4:0]))
    else $error("c");
  chk_d_int: assert property (wr(6'h15) |=> DIVIDER_O[27:21] == $past(DAT_I[6:0]))
    else $error("i");
  chk_d_low: assert property (wr(6'h16) |=> DIVIDER_O[7:0] == $past(DAT_I[7:0]))
    else $error("l");
  chk_d_mid: assert property (wr(6'h17) |=> DIVIDER_O[15:8] == $past(DAT_I[7:0]))
    else $error("m");
  chk_d_high: assert property (wr(6'h18) |=> DIVIDER_O[20:16] == $past(DAT_I[4:0]))
    else $error("h");
  chk_rst_vals: assert property ($fell(SYS_RST_I) |-> DIVIDER_O == 33'h108100000)
    else $error("r");
  chk_data_idle: assert property (!ACK_O |-> DAT_O == 32'h00000000)
    else $error("read data not zero outside ack");
endmodule
bind scdr_regs scdr_mon i_mon (.CLK_I, .SYS_RST_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I,
  .DAT_I, .DAT_O, .DIVIDER_O, .ACK_O);

// ==== bench/scdr_regs_test.sv ====
`timescale 1ns/1ps
module scdr_regs_test;
  logic clk = 0, rst = 1, req = 0, we = 0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] di = 32'h0, dout, rd;
  scdr_pkg::scdr_divider_type dv;
  int miscompares = 0, checks_done = 0, ticks = 0;
  logic [7:0] wv [5] = '{8'hDF, 8'hFF, 8'hA5, 8'h3C, 8'hCA};
  logic [7:0] rv [5] = '{8'h1F, 8'h7F, 8'hA5, 8'h3C, 8'h0A};
  scdr_regs i_scdr_regs (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(req), .STB_I(req), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(di), .DAT_O(dout), .ACK_O(ack), .DIVIDER_O(dv));
  initial forever #25 clk = ~clk;
  // ====================
  // run ends here
  task finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      miscompares++;
      finish_test;
    end
  end
  task cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    di <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dout;
    req <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp("reset", 33'h108100000, dv);
    for (int i = 0; i < 5; i++) acc(1'b1, 8'h50 + 8'(4 * i), 4'h1, {24'h0, wv[i]});
    cmp("divider", {5'h1F, 7'h7F, 5'h0A, 8'h3C, 8'hA5}, dv);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 8'h50 + 8'(4 * i), 4'h1, 32'h0);
      cmp("readback", {25'h0, rv[i]}, {1'b0, rd});
    end
    acc(1'b1, 8'h58, 4'h0, 32'h0);
    acc(1'b1, 8'h64, 4'h1, 32'hFF);
    acc(1'b0, 8'h64, 4'h1, 32'h0);
    cmp("unmapped", 33'h0, {1'b0, rd});
    cmp("refused", {5'h1F, 7'h7F, 5'h0A, 8'h3C, 8'hA5}, dv);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp("rerun", 33'h108100000, dv);
    finish_test;
  end
endmodule

// ==== common/scdr_pkg.sv ====
package scdr_pkg;

  // =====================================================================
  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_CHAN_C_FRACTION_HIGH = 6'h14;
  localparam logic [5:0] IDX_CHAN_D_INTEGER_OFFSET = 6'h15;
  localparam logic [5:0] IDX_CHAN_D_FRACTION_LOW = 6'h16;
  localparam logic [5:0] IDX_CHAN_D_FRACTION_MID = 6'h17;
  localparam logic [5:0] IDX_CHAN_D_FRACTION_HIGH = 6'h18;

  // =====================================================================
  // field layout
  localparam int FRACTION_W = 21;
  localparam int INTEGER_W = 7;
  localparam int FRAC_TOP_W = 5;
  localparam int RESERVED_BIT = 5;

  // =====================================================================
  // values after reset
  localparam logic [7:0] RST_CHAN_C_FRACTION_HIGH = 8'h10;
  localparam logic [7:0] RST_CHAN_D_INTEGER_OFFSET = 8'h40;
  localparam logic [7:0] RST_CHAN_D_FRACTION_LOW = 8'h00;
  localparam logic [7:0] RST_CHAN_D_FRACTION_MID = 8'h00;
  localparam logic [7:0] RST_CHAN_D_FRACTION_HIGH = 8'h10;

  // =====================================================================
  // divider settings handed to the synthesizer
  typedef struct packed {
    logic [FRAC_TOP_W-1:0] chan_c_fraction_top;
    logic [INTEGER_W-1:0] chan_d_integer;
    logic [FRACTION_W-1:0] chan_d_fraction;
  } scdr_divider_type;

endpackage

// ==== design/scdr_regs.sv ====
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps

// Function
// - C high register holds fraction bits 20:16
// - D integer offset in bits 6:0
// - D low register gives fraction bits 7:0
// - D mid register gives fraction bits 15:8
// - three D bytes form 21-bit fraction
// - D high register gives bits 20:16
module scdr_regs (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output scdr_pkg::scdr_divider_type DIVIDER_O
);

  // =====================================================================
  // storage and handshake state
  logic [7:0] chan_c_fraction_high_ff;
  logic [7:0] chan_d_integer_offset_ff;
  logic [7:0] chan_d_fraction_low_ff;
  logic [7:0] chan_d_fraction_mid_ff;
  logic [7:0] chan_d_fraction_high_ff;
  logic [7:0] nxt_chan_c_fraction_high;
  logic [7:0] nxt_chan_d_integer_offset;
  logic [7:0] nxt_chan_d_fraction_low;
  logic [7:0] nxt_chan_d_fraction_mid;
  logic [7:0] nxt_chan_d_fraction_high;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic access;
  logic rd_access;
  logic wr_lane0;
  logic [7:0] wr_byte;
  logic [5:0] idx;
  logic hit_c_high;
  logic hit_d_int;
  logic hit_d_low;
  logic hit_d_mid;
  logic hit_d_high;
  logic wr_c_high;
  logic wr_d_int;
  logic wr_d_low;
  logic wr_d_mid;
  logic wr_d_high;
  logic [7:0] nxt_rdata;

  // =====================================================================
  // bus decode
  // one access per request; the ack gap lets the master drop the strobe
  assign access = CYC_I & STB_I & ~ack_ff;
  assign rd_access = access & ~WE_I;
  // registers are byte wide, only lane 0 carries them
  assign wr_lane0 = access & WE_I & SEL_I[0];
  assign wr_byte = DAT_I[7:0];
  // address bits 1:0 and the upper lanes carry nothing for this bank
  assign idx = ADR_I[7:2];
  assign hit_c_high = (idx == scdr_pkg::IDX_CHAN_C_FRACTION_HIGH);
  assign hit_d_int = (idx == scdr_pkg::IDX_CHAN_D_INTEGER_OFFSET);
  assign hit_d_low = (idx == scdr_pkg::IDX_CHAN_D_FRACTION_LOW);
  assign hit_d_mid = (idx == scdr_pkg::IDX_CHAN_D_FRACTION_MID);
  assign hit_d_high = (idx == scdr_pkg::IDX_CHAN_D_FRACTION_HIGH);
  assign wr_c_high = wr_lane0 & hit_c_high;
  assign wr_d_int = wr_lane0 & hit_d_int;
  assign wr_d_low = wr_lane0 & hit_d_low;
  assign wr_d_mid = wr_lane0 & hit_d_mid;
  assign wr_d_high = wr_lane0 & hit_d_high;

  // =====================================================================
  // handshake: ack exactly one cycle after the taking edge
  always_comb begin
    nxt_ack = access;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // =====================================================================
  // read path
  // write only towards the synthesizer; read back is a debug aid
  always_comb begin
    case (idx)
      scdr_pkg::IDX_CHAN_C_FRACTION_HIGH: nxt_rdata = chan_c_fraction_high_ff;
      scdr_pkg::IDX_CHAN_D_INTEGER_OFFSET: nxt_rdata = chan_d_integer_offset_ff;
      scdr_pkg::IDX_CHAN_D_FRACTION_LOW: nxt_rdata = chan_d_fraction_low_ff;
      scdr_pkg::IDX_CHAN_D_FRACTION_MID: nxt_rdata = chan_d_fraction_mid_ff;
      scdr_pkg::IDX_CHAN_D_FRACTION_HIGH: nxt_rdata = chan_d_fraction_high_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // zero outside the ack cycle, so an or-tree bus needs no gating
  always_comb begin
    nxt_dat = 32'h00000000;
    if (rd_access) begin
      nxt_dat = {24'h000000, nxt_rdata};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      dat_ff <= 32'h00000000;
    end else begin
      dat_ff <= nxt_dat;
    end
  end

  // =====================================================================
  // channel C fraction bits 20:16
  // bits 7:6 unused and read zero; reserved bit 5 stored as written
  always_comb begin
    if (wr_c_high) begin
      nxt_chan_c_fraction_high = {2'h0, wr_byte[5:0]};
    end else begin
      nxt_chan_c_fraction_high = chan_c_fraction_high_ff;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      chan_c_fraction_high_ff <= scdr_pkg::RST_CHAN_C_FRACTION_HIGH;
    end else begin
      chan_c_fraction_high_ff <= nxt_chan_c_fraction_high;
    end
  end

  // =====================================================================
  // channel D integer offset
  // bit 7 unused, so it is never stored
  always_comb begin
    if (wr_d_int) begin
      nxt_chan_d_integer_offset = {1'b0, wr_byte[6:0]};
    end else begin
      nxt_chan_d_integer_offset = chan_d_integer_offset_ff;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      chan_d_integer_offset_ff <= scdr_pkg::RST_CHAN_D_INTEGER_OFFSET;
    end else begin
      chan_d_integer_offset_ff <= nxt_chan_d_integer_offset;
    end
  end

  // =====================================================================
  // channel D fraction bits 7:0
  // all eight bits carry the ratio
  always_comb begin
    if (wr_d_low) begin
      nxt_chan_d_fraction_low = wr_byte;
    end else begin
      nxt_chan_d_fraction_low = chan_d_fraction_low_ff;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      chan_d_fraction_low_ff <= scdr_pkg::RST_CHAN_D_FRACTION_LOW;
    end else begin
      chan_d_fraction_low_ff <= nxt_chan_d_fraction_low;
    end
  end

  // =====================================================================
  // channel D fraction bits 15:8
  // all eight bits carry the ratio
  always_comb begin
    if (wr_d_mid) begin
      nxt_chan_d_fraction_mid = wr_byte;
    end else begin
      nxt_chan_d_fraction_mid = chan_d_fraction_mid_ff;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      chan_d_fraction_mid_ff <= scdr_pkg::RST_CHAN_D_FRACTION_MID;
    end else begin
      chan_d_fraction_mid_ff <= nxt_chan_d_fraction_mid;
    end
  end

  // =====================================================================
  // channel D fraction bits 20:16
  // same layout as the channel C high register
  always_comb begin
    if (wr_d_high) begin
      nxt_chan_d_fraction_high = {2'h0, wr_byte[5:0]};
    end else begin
      nxt_chan_d_fraction_high = chan_d_fraction_high_ff;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      chan_d_fraction_high_ff <= scdr_pkg::RST_CHAN_D_FRACTION_HIGH;
    end else begin
      chan_d_fraction_high_ff <= nxt_chan_d_fraction_high;
    end
  end

  // =====================================================================
  // outputs; reserved bit never reaches the divider
  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;
  assign DIVIDER_O.chan_c_fraction_top = chan_c_fraction_high_ff[4:0];
  assign DIVIDER_O.chan_d_integer = chan_d_integer_offset_ff[6:0];
  // no shadowing: mixed ratios show between byte writes
  assign DIVIDER_O.chan_d_fraction = {chan_d_fraction_high_ff[4:0],
                                      chan_d_fraction_mid_ff,
                                      chan_d_fraction_low_ff};

endmodule
